// ### logic/ecl_error_logger.sv
// Top of the error capture logger: ECC path, capture registers, summary and interrupt.
`timescale 1ns/1ps
module ecl_error_logger #(
  parameter int ADDR_LO_W = ecl_pkg::ADDR_LO_W,
  parameter int ADDR_HI_W = ecl_pkg::ADDR_HI_W
) (
  input wire logic clk_i, // Core clock, 25 MHz.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  // Memory write path.
  input wire logic wr_valid_i, // Memory write this cycle.
  input wire logic [ecl_pkg::DATA_W-1:0] wr_data_i, // Write data.
  output logic [ecl_pkg::DATA_W-1:0] mem_wdata_o, // Data to memory.
  output logic [ecl_pkg::CHK_W-1:0] mem_wchk_o, // Check bits to memory.
  output logic mem_we_o, // Memory write strobe.
  // Diagnostic override.
  input wire logic diag_override_en_i, // Use override check bits.
  input wire logic [ecl_pkg::CHK_W-1:0] ecc_diag_override_reg_i, // Override check bits.
  // Read / checked path.
  input wire logic rd_valid_i, // Checked data present.
  input wire logic [ecl_pkg::DATA_W-1:0] rd_data_i, // Data read.
  input wire logic [ecl_pkg::CHK_W-1:0] rd_chk_i, // Check bits read.
  input wire logic [2:0] txn_type_i, // Transaction type code.
  input wire logic io_write_i, // Checked data is processor I/O write data.
  input wire logic loopback_i, // Access on the pseudo-DMA loopback path.
  input wire logic narrow_i, // Access narrower than a cache block.
  output logic [ecl_pkg::DATA_W-1:0] rd_data_o, // Corrected data.
  output logic rd_valid_o, // Corrected data valid.
  output logic probe_o, // Read and flush probe to processor and board cache.
  // Context for capture.
  input wire logic [ADDR_LO_W-1:0] mem_addr_lo_i, // Low memory address bits.
  input wire logic [ADDR_HI_W-1:0] mem_addr_hi_i, // High memory address bits.
  input wire logic [ecl_pkg::CMD_W-1:0] mem_cmd_i, // Active memory command.
  input wire logic [ecl_pkg::MASK_W-1:0] quad_valid_mask_i, // Quadword-valid mask.
  input wire logic [ecl_pkg::ST_W-1:0] queue_state_i, // Internal queue state.
  input wire logic translation_miss_flag_i, // Scatter/gather translation miss.
  input wire logic [1:0] data_source_code_i, // DMA read data source.
  input wire logic [ecl_pkg::PCI_ADDR_W-1:0] pci_addr_i, // PCI address.
  input wire logic [ecl_pkg::WIN_W-1:0] pci_window_i, // Hit PCI window.
  input wire logic pci_window_sg_i, // Hit window is scatter/gather.
  input wire logic [ecl_pkg::ST_W-1:0] pci_target_state_i, // Target state.
  input wire logic pci_cmd_write_i, // PCI command is a write.
  input wire logic [3:0] io_dma_state_i, // State code for I/O writes (2, 3 or 8).
  input wire logic mem_error_i, // Other memory error pulse.
  // Forced parity on the PCI side.
  input wire logic force_pci_par_i, // Pulse to arm forced parity.
  input wire logic pci_xfer_i, // PCI transaction this cycle.
  input wire logic pci_par_i, // True PCI parity.
  output logic pci_par_o, // Parity driven to PCI.
  // Software access.
  input wire logic summary_clr_i, // Pulse: one written to summary bit 0.
  output logic [ecl_pkg::SUMMARY_W-1:0] error_summary_reg_o, // Error summary.
  output logic [ecl_pkg::CHK_W-1:0] error_syndrome_reg_o, // Captured syndrome.
  output logic [ADDR_LO_W-1:0] memory_fault_addr_low_o, // Captured low address.
  output logic [ADDR_HI_W+ecl_pkg::CMD_W+ecl_pkg::MASK_W-1:0] memory_fault_addr_high_o, // Addr, cmd, mask.
  output logic [ecl_pkg::STAT_W-1:0] error_status_reg_o, // Captured status.
  output logic [ecl_pkg::PCI_ADDR_W-1:0] pci_fault_address_reg_o, // Captured PCI address.
  output logic [15:0] pci_fault_state_reg_o, // {rd/wr, sg, window, master, target}.
  output logic system_machine_check_irq_o // Machine-check interrupt to the processor.
);
  ecl_ecc_if wr_if();
  ecl_ecc_if rd_if();

  ecl_ecc_unit u_wr_ecc (.ecc(wr_if));
  ecl_ecc_unit u_rd_ecc (.ecc(rd_if));

  assign wr_if.data = wr_data_i;
  assign wr_if.chk = '0;
  assign rd_if.data = rd_data_i;
  assign rd_if.chk = rd_chk_i;

  logic pci_par_w;
  logic forced_w;
  ecl_parity_force u_force (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .arm_i(force_pci_par_i),
    .xfer_i(pci_xfer_i),
    .par_i(pci_par_i),
    .par_o(pci_par_w),
    .armed_o(),
    .fired_o(forced_w)
  );

  ecl_pkg::ecl_cap_state_t state_reg, state_next;
  logic [ecl_pkg::SUMMARY_W-1:0] summary_reg;
  logic err_any;
  logic dma_txn;
  logic capture;

  assign dma_txn = (txn_type_i == ecl_pkg::TT_DMA_RD) || (txn_type_i == ecl_pkg::TT_DMA_WR);
  assign err_any = (rd_valid_i && (rd_if.single_err || rd_if.double_err)) || mem_error_i;
  assign capture = err_any && (state_reg == ecl_pkg::ECL_ARMED);

  // Memory writes: data and strobe pass one cycle late, data stored as given.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_wdata_o <= '0;
      mem_we_o <= 1'b0;
    end else begin
      mem_we_o <= wr_valid_i;
      mem_wdata_o <= wr_data_i;
    end
  end

  // Check bits: the override replaces the generator whole, so a test can plant any pattern.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem_wchk_o <= '0;
    end else begin
      mem_wchk_o <= diag_override_en_i ? ecc_diag_override_reg_i : wr_if.gen_chk;
    end
  end

  // Read path forwards corrected data so a corrected error never stalls the transaction.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_valid_i;
      rd_data_o <= rd_if.single_err ? rd_if.corr_data : rd_data_i;
    end
  end

  // Narrow loopback accesses probe the caches whatever the window type.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      probe_o <= 1'b0;
    end else begin
      probe_o <= (rd_valid_i || wr_valid_i) && loopback_i && narrow_i;
    end
  end

  // Parity is registered so the pin still comes straight from a flip-flop.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pci_par_o <= 1'b0;
    end else begin
      pci_par_o <= pci_par_w;
    end
  end

  // Lock: any capture locks until software clears the summary bit.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ecl_pkg::ECL_ARMED: begin
        if (err_any) begin
          state_next = ecl_pkg::ECL_LOCKED;
        end
      end
      ecl_pkg::ECL_LOCKED: begin
        if (summary_clr_i && !err_any) begin
          state_next = ecl_pkg::ECL_ARMED;
        end
      end
      default: begin
        state_next = ecl_pkg::ECL_ARMED;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ecl_pkg::ECL_ARMED;
    end else begin
      state_reg <= state_next;
    end
  end

  // Summary bits: a new error in the clear cycle wins, so nothing is lost.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      summary_reg <= '0;
    end else begin
      if (summary_clr_i) begin
        summary_reg <= '0;
      end
      if (err_any) begin
        summary_reg[ecl_pkg::SUMMARY_BIT] <= 1'b1;
      end
      if (err_any && rd_valid_i && rd_if.double_err) begin
        summary_reg[ecl_pkg::UNCOR_BIT] <= 1'b1;
      end
      if (forced_w) begin
        summary_reg[ecl_pkg::FORCED_BIT] <= 1'b1;
      end
      if (err_any && state_reg == ecl_pkg::ECL_LOCKED) begin
        summary_reg[ecl_pkg::LOST_BIT] <= 1'b1;
      end
    end
  end

  // Machine-check line follows the summary bit; masking at level 31 is the processor's job.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      system_machine_check_irq_o <= 1'b0;
    end else begin
      system_machine_check_irq_o <= summary_reg[ecl_pkg::SUMMARY_BIT];
    end
  end

  assign error_summary_reg_o = summary_reg;

  // Syndrome capture, loaded only while unlocked; a non-ECC error leaves a zero syndrome.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      error_syndrome_reg_o <= '0;
    end else if (capture) begin
      error_syndrome_reg_o <= rd_valid_i ? rd_if.syndrome : ecl_pkg::SYN_ZERO;
    end
  end

  // Memory address capture; an I/O write carries no memory address worth keeping.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      memory_fault_addr_low_o <= '0;
      memory_fault_addr_high_o <= '0;
    end else if (capture && !io_write_i) begin
      memory_fault_addr_low_o <= mem_addr_lo_i;
      memory_fault_addr_high_o <= {mem_addr_hi_i, mem_cmd_i, quad_valid_mask_i};
    end
  end

  // Status capture: transaction type, queues, activity, miss flag, state and source.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      error_status_reg_o <= '0;
    end else if (capture) begin
      error_status_reg_o <= {queue_state_i,
                             (io_write_i ? io_dma_state_i :
                              ((txn_type_i == ecl_pkg::TT_DMA_WR) && !translation_miss_flag_i)
                                ? ecl_pkg::DMA_ST_HITWR : ecl_pkg::DMA_ST_READ),
                             translation_miss_flag_i && !io_write_i,
                             (txn_type_i == ecl_pkg::TT_DMA_RD) ? data_source_code_i : 2'h0,
                             dma_txn ? ecl_pkg::PCI_ACT_DMA : ecl_pkg::PCI_ACT_NONE,
                             txn_type_i};
    end
  end

  // PCI capture for DMA errors, with or without a translation miss.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pci_fault_address_reg_o <= '0;
      pci_fault_state_reg_o <= '0;
    end else if (capture && dma_txn) begin
      pci_fault_address_reg_o <= pci_addr_i;
      pci_fault_state_reg_o <= {4'h0, pci_cmd_write_i, translation_miss_flag_i | pci_window_sg_i,
                                pci_window_i, ecl_pkg::MASTER_IDLE, pci_target_state_i};
    end
  end

  // Checks on the write, read, probe, capture, lock, summary and interrupt logic.
  chk_lock_holds: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_reg == ecl_pkg::ECL_LOCKED && !summary_clr_i) |=> $stable(error_syndrome_reg_o))
    else $error("Syndrome changed while locked.");
  chk_lock_context: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state_reg == ecl_pkg::ECL_LOCKED && !summary_clr_i) |=> $stable(error_status_reg_o) && $stable(pci_fault_address_reg_o))
    else $error("Status or PCI capture changed while locked.");
  chk_summary_set: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_valid_i && rd_if.single_err) |=> summary_reg[ecl_pkg::SUMMARY_BIT])
    else $error("Correctable error did not set summary bit.");
  chk_clear_unlock: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (summary_clr_i && !err_any) |=> (summary_reg[ecl_pkg::SUMMARY_BIT] == 1'b0) ##1 !system_machine_check_irq_o)
    else $error("Summary clear did not dismiss error.");
  chk_irq_follows: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    err_any |=> ##1 system_machine_check_irq_o)
    else $error("Machine check not raised two cycles after error.");
  chk_override_chk: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    diag_override_en_i |=> mem_wchk_o == $past(ecc_diag_override_reg_i))
    else $error("Override check bits not written.");
  chk_probe_narrow: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_valid_i && loopback_i && narrow_i) |=> probe_o)
    else $error("Narrow loopback access missed probe.");
  chk_syn_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (capture && rd_valid_i) |=> error_syndrome_reg_o == $past(rd_if.syndrome))
    else $error("Syndrome not captured.");
  chk_addr_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (capture && !io_write_i) |=> memory_fault_addr_low_o == $past(mem_addr_lo_i))
    else $error("Low address not captured.");
  chk_high_capture: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (capture && !io_write_i) |=>
      memory_fault_addr_high_o == {$past(mem_addr_hi_i), $past(mem_cmd_i), $past(quad_valid_mask_i)})
    else $error("High address, command or mask not captured.");
  chk_io_no_addr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (capture && io_write_i) |=> $stable(memory_fault_addr_low_o) && $stable(memory_fault_addr_high_o))
    else $error("Memory address loaded on an I/O write error.");
  chk_status_context: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    capture |=> error_status_reg_o[15:12] == $past(queue_state_i) && error_status_reg_o[2:0] == $past(txn_type_i))
    else $error("Queue state or transaction type not captured.");
  chk_pci_master: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (capture && dma_txn) |=> pci_fault_state_reg_o[7:0] == {ecl_pkg::MASTER_IDLE, $past(pci_target_state_i)})
    else $error("Master or target state wrong on DMA capture.");
  chk_pci_address: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (capture && dma_txn) |=> pci_fault_address_reg_o == $past(pci_addr_i))
    else $error("PCI address not captured on DMA capture.");
  chk_forced_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    forced_w |=> summary_reg[ecl_pkg::FORCED_BIT])
    else $error("Forced parity not reported in the summary.");
  chk_corr_pass: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_valid_i && rd_if.single_err) |=> rd_valid_o && rd_data_o == $past(rd_if.corr_data))
    else $error("Corrected data not forwarded.");
endmodule

// ### include/ecl_pkg.sv
// Package with constants, field layouts and state codes of the error capture logger.
// Behaviour
// - Diagnostic override replaces generated check bits.
// - Narrow loopback accesses always probe caches.
// - Machine-check condition raises the system interrupt.
// - Correctable ECC error sets summary bit zero.
// - Writing one clears summary bit, dismisses error.
// - Capture registers stay locked until summary cleared.
// - Own ECC errors latch the syndrome.
// - Memory error latches low address bits.
// - Memory error latches high address, command, mask.
// - Status captures transaction type and queue state.
// - Status records activity code, miss flag, state.
// - DMA read source coded in two bits.
// - DMA error saves PCI address and target state.
// - Translation-miss error records scatter/gather window.
// - Processor I/O write error saves no address.
// - Force bit makes parity error, then self-clears.
package ecl_pkg;
  localparam int DATA_W = 64;
  localparam int CHK_W = 8;
  localparam int ADDR_LO_W = 16;
  localparam int ADDR_HI_W = 18;
  localparam int CMD_W = 4;
  localparam int MASK_W = 4;
  localparam int PCI_ADDR_W = 32;
  localparam int WIN_W = 2;
  localparam int ST_W = 4;
  localparam int SUMMARY_BIT = 0;
  localparam int SUMMARY_W = 4;
  localparam int UNCOR_BIT = 1;
  localparam int FORCED_BIT = 2;
  localparam int LOST_BIT = 3;
  localparam logic [1:0] PCI_ACT_DMA = 2'h1;
  localparam logic [1:0] PCI_ACT_NONE = 2'h0;
  localparam logic [3:0] DMA_ST_READ = 4'h6;
  localparam logic [3:0] DMA_ST_HITWR = 4'h7;
  localparam logic [1:0] SRC_MEM = 2'h1;
  localparam logic [1:0] SRC_SCACHE = 2'h2;
  localparam logic [1:0] SRC_BCACHE = 2'h3;
  localparam logic [3:0] MASTER_IDLE = 4'h0;
  // Error status layout: {queue_state[3:0], dma_state[3:0], miss, src[1:0], act[1:0], type[2:0]}.
  localparam int STAT_W = 16;
  localparam logic [2:0] TT_CPU_FILL = 3'h1;
  localparam logic [2:0] TT_DMA_RD = 3'h2;
  localparam logic [2:0] TT_DMA_WR = 3'h3;
  localparam logic [2:0] TT_IO_WR = 3'h4;
  localparam logic [7:0] SYN_ZERO = 8'h00;
  // Capture state machine.
  typedef enum logic [1:0] {
    ECL_ARMED = 2'b01,
    ECL_LOCKED = 2'b10
  } ecl_cap_state_t;
endpackage

// ### include/ecl_ecc_if.sv
// Interface carrying ECC generation and check signals between logger modules.
`timescale 1ns/1ps
interface ecl_ecc_if;
  logic [ecl_pkg::DATA_W-1:0] data;
  logic [ecl_pkg::CHK_W-1:0] chk;
  logic [ecl_pkg::CHK_W-1:0] gen_chk;
  logic [ecl_pkg::CHK_W-1:0] syndrome;
  logic [ecl_pkg::DATA_W-1:0] corr_data;
  logic single_err;
  logic double_err;
  modport checker_side (input data, input chk, output gen_chk, output syndrome, output corr_data,
                        output single_err, output double_err);
  modport user_side (output data, output chk, input gen_chk, input syndrome, input corr_data,
                     input single_err, input double_err);
endinterface

// ### logic/ecl_ecc_unit.sv
// Combinational SEC-DED generator, checker and single-bit corrector.
`timescale 1ns/1ps
module ecl_ecc_unit (
  ecl_ecc_if.checker_side ecc // Data and check bits in, results out.
);
  // Column code for a bit: the bit index on top, padded to an odd weight of three or more.
  // Odd weight keeps a single data error apart from a double, weight above one keeps it apart from a check bit.
  function automatic logic [7:0] col_code(input int idx);
    logic [5:0] v;
    logic [1:0] t;
    v = 6'(idx);
    t = 2'b00;
    if (^v == 1'b0) begin
      t = 2'b01;
    end else if ($countones(v) == 1) begin
      t = 2'b11;
    end
    // Index zero has no weight of its own, so it takes a pattern that no other index produces.
    if (v == 6'h00) begin
      v = 6'h03;
      t = 2'b10;
    end
    return {v, t};
  endfunction

  logic [7:0] gen;
  logic [ecl_pkg::DATA_W-1:0] flip;

  // Generated check bits are the XOR of the columns of all set data bits.
  always_comb begin
    gen = 8'h00;
    for (int i = 0; i < ecl_pkg::DATA_W; i++) begin
      if (ecc.data[i]) begin
        gen = gen ^ col_code(i);
      end
    end
  end

  // A data bit is flipped only when the syndrome matches its column exactly.
  for (genvar g = 0; g < ecl_pkg::DATA_W; g++) begin : g_fix
    assign flip[g] = (ecc.syndrome == col_code(g));
  end

  assign ecc.gen_chk = gen;
  assign ecc.syndrome = gen ^ ecc.chk;
  assign ecc.corr_data = ecc.data ^ flip;
  // Odd-weight syndrome is a single error; even nonzero is uncorrectable.
  assign ecc.single_err = (ecc.syndrome != ecl_pkg::SYN_ZERO) && (^ecc.syndrome);
  assign ecc.double_err = (ecc.syndrome != ecl_pkg::SYN_ZERO) && !(^ecc.syndrome);
endmodule

// ### logic/ecl_parity_force.sv
// One-shot parity inverter for a bus interface with a self-clearing force bit.
`timescale 1ns/1ps
module ecl_parity_force (
  input wire logic clk_i, // Core clock.
  input wire logic arst_n_i, // Asynchronous reset, active low.
  input wire logic arm_i, // Pulse to arm the force bit.
  input wire logic xfer_i, // A transaction goes out this cycle.
  input wire logic par_i, // Correct parity of the transaction.
  output logic par_o, // Parity to drive.
  output logic armed_o, // Force bit still pending.
  output logic fired_o // One-cycle pulse when parity was corrupted.
);
  logic armed_reg;

  // Arming wins over the clear so a re-arm on the firing cycle is kept.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      armed_reg <= 1'b0;
    end else if (arm_i) begin
      armed_reg <= 1'b1;
    end else if (xfer_i) begin
      armed_reg <= 1'b0;
    end
  end

  assign par_o = par_i ^ (armed_reg & xfer_i);
  assign armed_o = armed_reg;
  assign fired_o = armed_reg & xfer_i;

  chk_force_clears: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (armed_reg && xfer_i && !arm_i) |=> !armed_reg)
    else $error("Force bit did not clear after firing.");
endmodule

// ### dv/ecl_mem_model.sv
// Behavioural main memory word that stores what the logger writes and serves it back.
`timescale 1ns/1ps
module ecl_mem_model (
  input wire logic clk_i, // Core clock.
  input wire logic we_i, // Write strobe from the logger.
  input wire logic [63:0] wdata_i, // Data written.
  input wire logic [7:0] wchk_i, // Check bits written.
  input wire logic [63:0] flip_i, // Bits the bench corrupts on the read path.
  output logic [63:0] rdata_o, // Data read.
  output logic [7:0] rchk_o // Check bits read.
);
  logic [63:0] data_reg;
  logic [7:0] chk_reg;
  // Storage keeps bad check bits as they are, so a later read meets them unchanged.
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      data_reg <= wdata_i;
      chk_reg <= wchk_i;
    end
  end
  // The read path is always open; the flip mask stands in for a failing cell.
  assign rdata_o = data_reg ^ flip_i;
  assign rchk_o = chk_reg;
endmodule

// ### dv/ecl_error_logger_tb.sv
// Self-checking bench for the error capture logger with a memory partner model.
`timescale 1ns/1ps
module ecl_error_logger_tb;
  logic clk_i = '0, arst_n_i = '0, wr_valid_i = '0, diag_override_en_i = '0, rd_valid_i = '0;
  logic io_write_i = '0, loopback_i = '0, narrow_i = '0, translation_miss_flag_i = '0, pci_window_sg_i = '0;
  logic pci_cmd_write_i = '0, mem_error_i = '0, force_pci_par_i = '0, pci_xfer_i = '0, pci_par_i = '0;
  logic summary_clr_i = '0;
  logic [63:0] wr_data_i = '0, flip = '0, rd_data_i, mem_wdata_o, rd_data_o, d;
  logic [7:0] ecc_diag_override_reg_i = '0, rd_chk_i, mem_wchk_o, error_syndrome_reg_o, g;
  logic [2:0] txn_type_i = '0;
  logic [15:0] mem_addr_lo_i = '0, memory_fault_addr_low_o, error_status_reg_o, pci_fault_state_reg_o;
  logic [15:0] e_lo = '0, e_st, e_ps;
  logic [17:0] mem_addr_hi_i = '0;
  logic [3:0] mem_cmd_i = '0, quad_valid_mask_i = '0, queue_state_i = '0, pci_target_state_i = '0;
  logic [3:0] io_dma_state_i = '0, error_summary_reg_o;
  logic [1:0] data_source_code_i = '0, pci_window_i = '0;
  logic [31:0] pci_addr_i = '0, pci_fault_address_reg_o, e_pa;
  logic [25:0] memory_fault_addr_high_o, e_hi = '0;
  logic mem_we_o, rd_valid_o, probe_o, pci_par_o, system_machine_check_irq_o;
  int fail_count = 0;
  int samples_checked = 0;

  // Free-running core clock, 40 ns period.
  always #20 clk_i = ~clk_i;

  ecl_error_logger u_ecl_error_logger (.*);
  ecl_mem_model u_ecl_mem_model (.clk_i(clk_i), .we_i(mem_we_o), .wdata_i(mem_wdata_o), .wchk_i(mem_wchk_o),
    .flip_i(flip), .rdata_o(rd_data_i), .rchk_o(rd_chk_i));

  // Compare one value; case inequality so an unknown never passes.
  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Expected status word worked out from the context the bench drives.
  function automatic logic [15:0] exp_st();
    logic rdd, wrd;
    logic [3:0] ds;
    rdd = txn_type_i == ecl_pkg::TT_DMA_RD;
    wrd = txn_type_i == ecl_pkg::TT_DMA_WR;
    ds = io_write_i ? io_dma_state_i :
         (wrd && !translation_miss_flag_i) ? ecl_pkg::DMA_ST_HITWR : ecl_pkg::DMA_ST_READ;
    return {queue_state_i, ds, translation_miss_flag_i, rdd ? data_source_code_i : 2'h0,
            (rdd || wrd) ? ecl_pkg::PCI_ACT_DMA : ecl_pkg::PCI_ACT_NONE, txn_type_i};
  endfunction

  // One memory write through the logger, optionally with override check bits.
  task automatic wr(input logic ov, input logic [7:0] oc);
    @(posedge clk_i);
    wr_valid_i <= 1'h1;
    wr_data_i <= d;
    diag_override_en_i <= ov;
    ecc_diag_override_reg_i <= oc;
    @(posedge clk_i);
    wr_valid_i <= 1'h0;
    @(negedge clk_i);
  endtask

  // Random context for transaction kind i: 0-3 DMA read (3 misses), 4-5 DMA write (4 misses), 6-8 I/O write.
  task automatic ctx(input int i);
    @(posedge clk_i);
    txn_type_i <= i < 4 ? ecl_pkg::TT_DMA_RD : i < 6 ? ecl_pkg::TT_DMA_WR : ecl_pkg::TT_IO_WR;
    io_write_i <= i > 5;
    translation_miss_flag_i <= i == 3 || i == 4;
    pci_window_sg_i <= i == 3 || i == 4;
    data_source_code_i <= i < 3 ? 2'(i + 1) : 2'($urandom);
    io_dma_state_i <= i == 6 ? 4'h2 : i == 7 ? 4'h3 : 4'h8;
    mem_addr_lo_i <= 16'($urandom);
    mem_addr_hi_i <= 18'($urandom);
    mem_cmd_i <= 4'($urandom);
    quad_valid_mask_i <= 4'($urandom);
    queue_state_i <= 4'($urandom);
    pci_addr_i <= $urandom;
    pci_window_i <= 2'($urandom);
    pci_target_state_i <= 4'($urandom_range(15, 1));
    pci_cmd_write_i <= i > 3;
    @(negedge clk_i);
  endtask

  // One checked read with the given corruption, then the captured state is compared.
  task automatic rd(input logic [63:0] f);
    e_st = exp_st();
    e_ps = {4'h0, pci_cmd_write_i, pci_window_sg_i, pci_window_i, 4'h0, pci_target_state_i};
    // An I/O write error leaves the PCI and memory address captures as they were.
    if (!io_write_i) begin
      e_pa = pci_addr_i;
      e_lo = mem_addr_lo_i;
      e_hi = {mem_addr_hi_i, mem_cmd_i, quad_valid_mask_i};
    end
    @(posedge clk_i);
    rd_valid_i <= 1'h1;
    flip <= f;
    @(posedge clk_i);
    rd_valid_i <= 1'h0;
    flip <= '0;
    @(negedge clk_i);
    chk(error_summary_reg_o[1:0], 2'h1, "summary");
    chk(error_syndrome_reg_o != 8'h00, 1, "syndrome");
    chk({rd_valid_o, rd_data_o}, {1'h1, d}, "corrected data");
    chk(memory_fault_addr_low_o, e_lo, "addr low");
    chk(memory_fault_addr_high_o, e_hi, "addr high");
    chk(error_status_reg_o, e_st, "status");
    if (!io_write_i) begin
      chk(pci_fault_address_reg_o, e_pa, "pci addr");
      chk(pci_fault_state_reg_o, e_ps, "pci state");
    end
    chk(system_machine_check_irq_o, 0, "irq early");
    @(negedge clk_i);
    chk(system_machine_check_irq_o, 1, "irq");
  endtask

  // A second error while locked must not disturb the captures; then software clears.
  task automatic lock_clr;
    @(posedge clk_i);
    mem_error_i <= 1'h1;
    mem_addr_lo_i <= ~mem_addr_lo_i;
    queue_state_i <= ~queue_state_i;
    pci_addr_i <= ~pci_addr_i;
    @(posedge clk_i);
    mem_error_i <= 1'h0;
    @(negedge clk_i);
    chk(error_summary_reg_o[3], 1, "lost flag");
    chk({memory_fault_addr_low_o, error_status_reg_o}, {e_lo, e_st}, "locked regs");
    chk(pci_fault_address_reg_o, e_pa, "locked pci");
    @(posedge clk_i);
    summary_clr_i <= 1'h1;
    @(posedge clk_i);
    summary_clr_i <= 1'h0;
    @(negedge clk_i);
    chk(error_summary_reg_o, 0, "summary clear");
    @(negedge clk_i);
    chk(system_machine_check_irq_o, 0, "irq clear");
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'hb53e80f4));
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'h1;
    @(negedge clk_i);
    chk({error_summary_reg_o, system_machine_check_irq_o}, 0, "reset state");
    $display("test reset done");
    d = {$urandom, $urandom};
    wr(1'h0, 8'h00);
    chk({mem_we_o, mem_wdata_o}, {1'h1, d}, "write path");
    g = mem_wchk_o;
    wr(1'h1, g ^ 8'h01);
    chk(mem_wchk_o, g ^ 8'h01, "override bits");
    ctx(0);
    rd('0);
    lock_clr();
    $display("test override done");
    // Every transaction kind, with a random single data bit failing; each reloads after the clear.
    for (int i = 0; i < 9; i++) begin
      d = {$urandom, $urandom};
      wr(1'h0, 8'h00);
      ctx(i);
      rd(64'h1 << $urandom_range(63, 0));
      lock_clr();
    end
    $display("test capture done");
    for (int k = 1; k >= 0; k--) begin
      @(posedge clk_i);
      loopback_i <= k[0];
      narrow_i <= 1'h1;
      rd_valid_i <= 1'h1;
      @(posedge clk_i);
      rd_valid_i <= 1'h0;
      @(negedge clk_i);
      chk(probe_o, k, "cache probe");
    end
    $display("test probe done");
    @(posedge clk_i);
    force_pci_par_i <= 1'h1;
    @(posedge clk_i);
    force_pci_par_i <= 1'h0;
    pci_xfer_i <= 1'h1;
    pci_par_i <= 1'h1;
    repeat (2) @(negedge clk_i);
    chk({pci_par_o, error_summary_reg_o[2]}, 2'h1, "forced parity");
    @(posedge clk_i);
    pci_xfer_i <= 1'h0;
    @(negedge clk_i);
    chk(pci_par_o, 1, "force cleared");
    $display("test force done");
    results();
  end

  // Watchdog: the whole sequence needs about 130 cycles.
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    results();
  end
endmodule
